// >>> hw/usbc_dev_ctrl.sv
// Functional notes
// - OUT transfer first packet uses loaded PID
// - IN first packet PID mismatch raises error
// - PID toggles by itself after each packet without a toggle error
// - PID codes DATA0, DATA1, SETUP; 01 reserved
// - Ten-bit packet count decrements per packet
// - OUT length drops per FIFO packet written
// - IN length drops per FIFO packet read
// - Global OUT NAK: NAK all, store nothing
// - Set IN NAK, effective flag follows later
// - Soft disconnect removes data line pull-up
// - Remote wakeup while suspended signals resume
`timescale 1ns/1ns
module usbc_dev_ctrl #(
    parameter int FRAME_CYCLES = usbc_pkg::FRAME_CYC
) (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic                     hresp,
    output logic [31:0]              hrdata,
    // Packet engine
    input  wire usbc_pkg::usbc_evt_s pktEvt,
    input  wire usbc_pkg::usbc_tok_s token,
    input  wire logic                sofPulse,
    input  wire logic                statusOutNonZero,
    input  wire logic                suspended,
    output logic [1:0]               txPid,
    output logic                     addrMatch,
    output logic                     fullSpeedSel,
    output logic                     statusOutStall,
    output logic                     outNak,
    output logic                     inNak,
    output logic                     rxStoreEn,
    // Bus pins and interrupt
    output logic                     pullupEn,
    output logic                     resumeSignal,
    output logic                     irq
);

    // ***********************************************************
    // Register state
    // ***********************************************************
    localparam int FRM_W = usbc_pkg::FRM_CNT_W;
    logic [31:0]            cfg_reg;
    logic [11:0]            ctl_reg;
    logic [1:0]             pid_reg,  pid_next;
    logic [9:0]             packet_countdown_reg, packet_countdown_next;
    logic [18:0]            len_reg,  len_next;
    logic                   chOut_reg;
    logic                   first_reg;
    usbc_pkg::usbc_chan_e   chan_reg, chan_next;
    logic [4:0]             stat_reg, stat_next, mask_reg;
    logic [2:0]             nakCnt_reg [2];
    logic [FRM_W-1:0]       frm_reg;
    logic                   wrPend_reg;
    logic [11:0]            wrAddr_reg;
    logic                   match_reg;

    // ***********************************************************
    // Bus decode
    // ***********************************************************
    // Zero wait states; read data is latched at the address phase so hrdata is a flop
    wire        busHit   = hsel & htrans[1] & hready;
    wire        rdHit    = busHit & ~hwrite;
    wire [11:0] rdAddr   = haddr[11:0];
    wire        inMap    = (haddr[31:12] == 20'h0);
    wire        wrCfg    = wrPend_reg & (wrAddr_reg == usbc_pkg::OFS_DEV_CFG);
    wire        wrCtl    = wrPend_reg & (wrAddr_reg == usbc_pkg::OFS_DEV_CTL);
    wire        wrXfer   = wrPend_reg & (wrAddr_reg == usbc_pkg::OFS_XFER_SIZE);
    wire        wrChan   = wrPend_reg & (wrAddr_reg == usbc_pkg::OFS_CHAN_CTL);
    wire        wrMask   = wrPend_reg & (wrAddr_reg == usbc_pkg::OFS_INT_MASK);
    wire        rdStat   = rdHit & inMap & (rdAddr == usbc_pkg::OFS_INT_STAT);
    wire [1:0]  wrPid    = hwdata[usbc_pkg::XS_PID_LSB +: 2];

    // Read mux; control command bits read as zero
    wire [31:0] xferWord = {1'b0, pid_reg, packet_countdown_reg, len_reg};
    wire [31:0] ctlWord  = {20'h0, ctl_reg[11], 4'h0, 3'h0, ctl_reg[3:0]};
    wire [31:0] chanWord = {30'h0, chOut_reg, chan_reg == usbc_pkg::CH_RUN};
    wire [31:0] rdMux    = !inMap ? 32'h0 :
                           (rdAddr == usbc_pkg::OFS_DEV_CFG)   ? cfg_reg :
                           (rdAddr == usbc_pkg::OFS_DEV_CTL)   ? ctlWord :
                           (rdAddr == usbc_pkg::OFS_XFER_SIZE) ? xferWord :
                           (rdAddr == usbc_pkg::OFS_CHAN_CTL)  ? chanWord :
                           (rdAddr == usbc_pkg::OFS_INT_STAT)  ? {27'h0, stat_reg} :
                           (rdAddr == usbc_pkg::OFS_INT_MASK)  ? {27'h0, mask_reg} : 32'h0;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Address phase capture
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 12'h0;
            hrdata     <= 32'h0;
        end else begin
            wrPend_reg <= busHit & hwrite & inMap;
            wrAddr_reg <= haddr[11:0];
            if (rdHit)
                hrdata <= rdMux;
        end
    end

    // ***********************************************************
    // Configuration fields
    // ***********************************************************
    wire [1:0] eopSel = cfg_reg[usbc_pkg::CFG_EOP_LSB +: 2];
    wire [6:0] devAddr = cfg_reg[usbc_pkg::CFG_DAR_LSB +: 7];
    wire [1:0] speed  = cfg_reg[usbc_pkg::CFG_DS_LSB +: 2];
    wire       nzStall = cfg_reg[usbc_pkg::CFG_NZS_BIT];

    // Reserved bits stay at zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            cfg_reg <= usbc_pkg::RST_DEV_CFG;
        else if (wrCfg)
            cfg_reg <= {19'h0, hwdata[12:4], 1'b0, hwdata[2:0]};
    end

    assign fullSpeedSel   = (speed == usbc_pkg::SPEED_FS);
    assign statusOutStall = nzStall & statusOutNonZero;

    // Registered match keeps the compare off the token path
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            match_reg <= 1'b0;
        else
            match_reg <= token.valid & (token.addr == devAddr);
    end
    assign addrMatch = match_reg;

    // ***********************************************************
    // Device control and global NAK
    // ***********************************************************
    wire gonsSet = wrCtl & hwdata[usbc_pkg::CTL_SGON];
    wire ginsSet = wrCtl & hwdata[usbc_pkg::CTL_SGIN];
    wire [1:0] nakStart = {gonsSet & ~ctl_reg[usbc_pkg::CTL_GLOBAL_OUT_NAK_STATE],
                           ginsSet & ~ctl_reg[usbc_pkg::CTL_GLOBAL_IN_NAK_STATE]};
    wire [1:0] nakDone;

    // Set command wins if software sets and clears in one write
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ctl_reg <= usbc_pkg::RST_DEV_CTL[11:0];
        end else if (wrCtl) begin
            ctl_reg[11] <= hwdata[usbc_pkg::CTL_POWER_ON_INIT_DONE];
            ctl_reg[1]  <= hwdata[usbc_pkg::CTL_SD];
            ctl_reg[0]  <= hwdata[usbc_pkg::CTL_RWK];
            ctl_reg[3]  <= gonsSet | (ctl_reg[3] & ~hwdata[usbc_pkg::CTL_CGON]);
            ctl_reg[2]  <= ginsSet | (ctl_reg[2] & ~hwdata[usbc_pkg::CTL_CGIN]);
        end
    end

    // Effective flags land a fixed delay after the NAK state takes hold
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < 2; i++) begin
            if (sys_rst)
                nakCnt_reg[i] <= 3'h0;
            else if (nakStart[i])
                nakCnt_reg[i] <= 3'(usbc_pkg::NAK_EFF_CYC);
            else if (nakCnt_reg[i] != 3'h0)
                nakCnt_reg[i] <= nakCnt_reg[i] - 3'h1;
        end
    end
    assign nakDone[0] = (nakCnt_reg[0] == 3'h1);
    assign nakDone[1] = (nakCnt_reg[1] == 3'h1);

    assign outNak       = ctl_reg[usbc_pkg::CTL_GLOBAL_OUT_NAK_STATE];
    assign rxStoreEn    = ~ctl_reg[usbc_pkg::CTL_GLOBAL_OUT_NAK_STATE] & ~statusOutStall;
    assign inNak        = ctl_reg[usbc_pkg::CTL_GLOBAL_IN_NAK_STATE];
    assign pullupEn     = ~ctl_reg[usbc_pkg::CTL_SD];
    assign resumeSignal = ctl_reg[usbc_pkg::CTL_RWK] & suspended;

    // ***********************************************************
    // Channel transfer
    // ***********************************************************
    wire running  = (chan_reg == usbc_pkg::CH_RUN);
    wire rxMis    = running & ~chOut_reg & pktEvt.rxPktDone & first_reg & (pktEvt.rxPid != pid_reg);
    wire advance  = running & ((chOut_reg & pktEvt.txPktDone) | (~chOut_reg & pktEvt.rxPktDone & ~rxMis));
    wire lenEvt   = running & ((chOut_reg & pktEvt.fifoWrDone) | (~chOut_reg & pktEvt.fifoRdDone));
    wire [18:0] lenSub = {8'h0, pktEvt.byteCount};
    wire lastPkt  = advance & (packet_countdown_reg == 10'h1);
    wire [1:0] pidToggled = (pid_reg == usbc_pkg::PID_DATA1) ? usbc_pkg::PID_DATA0
                                                               : usbc_pkg::PID_DATA1;

    // Counters and PID; a register write overrides engine updates
    always_comb begin
        pid_next  = pid_reg;
        packet_countdown_next = packet_countdown_reg;
        len_next  = len_reg;
        chan_next = chan_reg;
        if (advance) begin
            pid_next  = pidToggled;
            packet_countdown_next = (packet_countdown_reg == 10'h0) ? 10'h0 : packet_countdown_reg - 10'h1;
        end
        if (lenEvt)
            len_next = (len_reg > lenSub) ? len_reg - lenSub : 19'h0;
        if (wrXfer) begin
            pid_next  = (wrPid == usbc_pkg::PID_RSVD) ? usbc_pkg::PID_DATA0 : wrPid;
            packet_countdown_next = hwdata[usbc_pkg::XS_PACKET_COUNTDOWN_LSB +: 10];
            len_next  = hwdata[usbc_pkg::XS_LEN_LSB +: 19];
        end
        unique case (chan_reg)
            usbc_pkg::CH_IDLE: if (wrChan && hwdata[usbc_pkg::CH_EN_BIT]) chan_next = usbc_pkg::CH_RUN;
            usbc_pkg::CH_RUN: begin
                if (lastPkt || (wrChan && !hwdata[usbc_pkg::CH_EN_BIT]))
                    chan_next = usbc_pkg::CH_IDLE;
            end
        endcase
    end

    // Transfer state flops
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pid_reg   <= usbc_pkg::RST_XFER_SIZE[30:29];
            packet_countdown_reg  <= usbc_pkg::RST_XFER_SIZE[28:19];
            len_reg   <= usbc_pkg::RST_XFER_SIZE[18:0];
            chan_reg  <= usbc_pkg::CH_IDLE;
            chOut_reg <= 1'b0;
            first_reg <= 1'b0;
        end else begin
            pid_reg   <= pid_next;
            packet_countdown_reg  <= packet_countdown_next;
            len_reg   <= len_next;
            chan_reg  <= chan_next;
            if (wrChan && !running)
                chOut_reg <= hwdata[usbc_pkg::CH_OUT_BIT];
            if (chan_next == usbc_pkg::CH_RUN && !running)
                first_reg <= 1'b1;
            else if (running && (pktEvt.rxPktDone || pktEvt.txPktDone))
                first_reg <= 1'b0;
        end
    end

    assign txPid = pid_reg;

    // ***********************************************************
    // Frame timer
    // ***********************************************************
    // SOF restarts the count so the end point follows the host's frame
    wire [FRM_W-1:0] frmPoint = (eopSel == 2'h0) ? FRM_W'(FRAME_CYCLES * 80 / 100) :
                                (eopSel == 2'h1) ? FRM_W'(FRAME_CYCLES * 85 / 100) :
                                (eopSel == 2'h2) ? FRM_W'(FRAME_CYCLES * 90 / 100) :
                                                   FRM_W'(FRAME_CYCLES * 95 / 100);
    wire frmEnd = ~sofPulse & (frm_reg == frmPoint);

    always_ff @(posedge sys_clk) begin
        if (sys_rst || sofPulse)
            frm_reg <= '0;
        else if (frm_reg != FRM_W'(FRAME_CYCLES))
            frm_reg <= frm_reg + 1'b1;
    end

    // ***********************************************************
    // Interrupts
    // ***********************************************************
    wire [4:0] evtVec = {lastPkt, nakDone[1], nakDone[0], frmEnd, rxMis};

    // Read clears, but an event in the same cycle survives
    always_comb begin
        stat_next = (rdStat ? 5'h0 : stat_reg) | evtVec;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stat_reg <= 5'h0;
            mask_reg <= 5'h0;
        end else begin
            stat_reg <= stat_next;
            if (wrMask)
                mask_reg <= hwdata[4:0];
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // ***********************************************************
    // Checks
    // ***********************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_gin_cmd;
        ginsSet && !ctl_reg[usbc_pkg::CTL_GLOBAL_IN_NAK_STATE];
    endsequence
    sequence s_gin_eff;
        ##[1:8] stat_reg[usbc_pkg::IRQ_INNAK];
    endsequence

    property p_first_pid;
        wrXfer && wrPid != usbc_pkg::PID_RSVD |=> txPid == $past(wrPid);
    endproperty
    a_first_pid: assert property (p_first_pid) else $error("first PID not loaded");

    property p_toggle_err;
        rxMis |=> stat_reg[usbc_pkg::IRQ_TOGERR] && packet_countdown_reg == $past(packet_countdown_reg);
    endproperty
    a_toggle_err: assert property (p_toggle_err) else $error("toggle error missed");

    property p_toggle;
        advance && !wrXfer && pid_reg == usbc_pkg::PID_DATA0 |=> pid_reg == usbc_pkg::PID_DATA1;
    endproperty
    a_toggle: assert property (p_toggle) else $error("PID did not toggle");

    property p_pid_legal;
        pid_reg != usbc_pkg::PID_RSVD;
    endproperty
    a_pid_legal: assert property (p_pid_legal) else $error("reserved PID held");

    property p_packet_countdown;
        advance && !wrXfer && packet_countdown_reg != 10'h0 |=> packet_countdown_reg == $past(packet_countdown_reg) - 10'h1;
    endproperty
    a_packet_countdown: assert property (p_packet_countdown) else $error("packet count not decremented");

    property p_len;
        lenEvt && !wrXfer && len_reg > lenSub |=> len_reg == $past(len_reg) - $past(lenSub);
    endproperty
    a_len: assert property (p_len) else $error("length not reduced");

    property p_frame_end;
        frmEnd |=> stat_reg[usbc_pkg::IRQ_FRMEND];
    endproperty
    a_frame_end: assert property (p_frame_end) else $error("frame end flag missed");

    property p_addr;
        token.valid && token.addr == devAddr |=> addrMatch;
    endproperty
    a_addr: assert property (p_addr) else $error("address match missed");

    property p_out_nak;
        wrCtl && hwdata[usbc_pkg::CTL_SGON] |=> outNak && !rxStoreEn;
    endproperty
    a_out_nak: assert property (p_out_nak) else $error("OUT data stored under NAK");

    property p_in_nak;
        s_gin_cmd |=> inNak ##0 s_gin_eff;
    endproperty
    a_in_nak: assert property (p_in_nak) else $error("IN NAK effect late");

    property p_disconnect;
        wrCtl && hwdata[usbc_pkg::CTL_SD] |=> !pullupEn [*2];
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("pull-up still on");

    property p_wakeup;
        ctl_reg[usbc_pkg::CTL_RWK] && suspended |-> resumeSignal;
    endproperty
    a_wakeup: assert property (p_wakeup) else $error("resume not signalled");

endmodule : usbc_dev_ctrl

// >>> hw/usbc_pkg.sv
package usbc_pkg;

    // ***********************************************************
    // Register map (byte addresses, low 12 bits)
    // ***********************************************************
    localparam logic [11:0] OFS_DEV_CFG   = 12'h800;
    localparam logic [11:0] OFS_DEV_CTL   = 12'h804;
    localparam logic [11:0] OFS_XFER_SIZE = 12'h900;
    localparam logic [11:0] OFS_CHAN_CTL  = 12'h904;
    localparam logic [11:0] OFS_INT_STAT  = 12'h908;
    localparam logic [11:0] OFS_INT_MASK  = 12'h90c;

    // ***********************************************************
    // Reset values
    // ***********************************************************
    localparam logic [31:0] RST_DEV_CFG   = 32'h0000_0000;
    localparam logic [31:0] RST_DEV_CTL   = 32'h0000_0000;
    localparam logic [31:0] RST_XFER_SIZE = 32'h0000_0000;

    // ***********************************************************
    // Field positions
    // ***********************************************************
    localparam int XS_PID_LSB  = 29;
    localparam int XS_PACKET_COUNTDOWN_LSB = 19;
    localparam int XS_LEN_LSB  = 0;
    localparam int CFG_EOP_LSB = 11;
    localparam int CFG_DAR_LSB = 4;
    localparam int CFG_NZS_BIT = 2;
    localparam int CFG_DS_LSB  = 0;
    localparam int CTL_POWER_ON_INIT_DONE    = 11;
    localparam int CTL_CGON    = 10;
    localparam int CTL_SGON    = 9;
    localparam int CTL_CGIN    = 8;
    localparam int CTL_SGIN    = 7;
    localparam int CTL_GLOBAL_OUT_NAK_STATE    = 3;
    localparam int CTL_GLOBAL_IN_NAK_STATE    = 2;
    localparam int CTL_SD      = 1;
    localparam int CTL_RWK     = 0;
    localparam int CH_EN_BIT   = 0;
    localparam int CH_OUT_BIT  = 1;

    // Interrupt status bits
    localparam int IRQ_TOGERR  = 0;
    localparam int IRQ_FRMEND  = 1;
    localparam int IRQ_INNAK   = 2;
    localparam int IRQ_OUTNAK  = 3;
    localparam int IRQ_XFERDN  = 4;
    localparam int IRQ_W       = 5;

    // ***********************************************************
    // Encodings
    // ***********************************************************
    localparam logic [1:0] PID_DATA0 = 2'h0;
    localparam logic [1:0] PID_RSVD  = 2'h1;
    localparam logic [1:0] PID_DATA1 = 2'h2;
    localparam logic [1:0] PID_SETUP = 2'h3;
    localparam logic [1:0] SPEED_FS  = 2'h3;

    // ***********************************************************
    // Timing
    // ***********************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int FRAME_TIME_NS = 1000000;
    localparam int FRAME_CYC     = FRAME_TIME_NS / CLK_PERIOD_NS;
    localparam int NAK_EFF_NS    = 100;
    localparam int NAK_EFF_CYC   = (NAK_EFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FRM_CNT_W     = 20;

    typedef enum logic [0:0] {CH_IDLE, CH_RUN} usbc_chan_e;

    // Packet engine events; the done flags are one-cycle strobes
    typedef struct packed {
        logic        txPktDone;
        logic        rxPktDone;
        logic [1:0]  rxPid;
        logic        fifoWrDone;
        logic        fifoRdDone;
        logic [10:0] byteCount;
    } usbc_evt_s;

    // Token seen on the bus
    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
    } usbc_tok_s;

endpackage : usbc_pkg

// >>> verif/tb_usb_fs_transfer_and_device_config.sv
`timescale 1ns/1ns
module tb_usb_fs_transfer_and_device_config;
    localparam int FRM = 200;
    logic                sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp, sofPulse;
    logic                statusOutNonZero, suspended, addrMatch, fullSpeedSel, statusOutStall;
    logic                outNak, inNak, rxStoreEn, pullupEn, resumeSignal, irq;
    logic [1:0]          htrans, txPid;
    logic [31:0]         haddr, hwdata, hrdata, rd;
    usbc_pkg::usbc_evt_s pktEvt;
    usbc_pkg::usbc_tok_s token;
    int                  badCount, testsRun;

    // Short frame so the end point arrives in under two hundred cycles
    usbc_dev_ctrl #(.FRAME_CYCLES(FRM)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pktEvt(pktEvt), .token(token), .sofPulse(sofPulse),
        .statusOutNonZero(statusOutNonZero), .suspended(suspended), .txPid(txPid),
        .addrMatch(addrMatch), .fullSpeedSel(fullSpeedSel), .statusOutStall(statusOutStall),
        .outNak(outNak), .inNak(inNak), .rxStoreEn(rxStoreEn), .pullupEn(pullupEn),
        .resumeSignal(resumeSignal), .irq(irq));
    usbc_host_model host_u (.sys_clk(sys_clk), .pktEvt(pktEvt), .token(token), .sofPulse(sofPulse));

    // 50 MHz clock
    initial sys_clk = 1'b0;
    always #10 sys_clk = ~sys_clk;

    // ************************************************
    // Bench tasks
    // ************************************************
    task automatic tallyAndFinish();
        $display("checks %0d mismatches %0d", testsRun, badCount);
        if (badCount == 0 && testsRun > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tallyAndFinish

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        testsRun++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            badCount++;
        end
    endtask : chk

    task automatic chkB(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask : chkB

    // Bounded wait for hready at a rising edge
    task automatic waitRdy();
        int n = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                badCount++;
                tallyAndFinish();
            end
            @(posedge sys_clk);
        end
    endtask : waitRdy

    // Single word transfer; read data taken at the data phase edge
    task automatic ahb(input logic [11:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0, a};
        hwrite <= w;
        waitRdy();
        htrans <= 2'h0;
        hwdata <= d;
        waitRdy();
        rd = hrdata;
        chkB("hresp", 1'b0, hresp);
    endtask : ahb

    task automatic rdChk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        ahb(a, 1'b0, 32'h0);
        chk(nm, e, rd & m);
    endtask : rdChk

    function automatic logic [31:0] xs(input logic [1:0] p, input logic [9:0] c, input logic [18:0] l);
        return {1'b0, p, c, l};
    endfunction : xs

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        sys_rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        statusOutNonZero = 1'b0;
        suspended = 1'b0;
        badCount = 0;
        testsRun = 0;
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        rdChk(usbc_pkg::OFS_DEV_CFG, '1, usbc_pkg::RST_DEV_CFG, "devCfg");
        rdChk(usbc_pkg::OFS_XFER_SIZE, '1, usbc_pkg::RST_XFER_SIZE, "xferSize");
        rdChk(12'h8fc, '1, 32'h0, "unmapped");
        chkB("pullupEn", 1'b1, pullupEn);
        $display("test reset done");
        // Every PID code; reserved code reads back as DATA0
        for (int p = 0; p < 4; p++) begin
            ahb(usbc_pkg::OFS_XFER_SIZE, 1'b1, xs(p[1:0], 10'h1, 19'h4));
            rdChk(usbc_pkg::OFS_XFER_SIZE, 32'h6000_0000, {1'b0, (p == 1) ? 2'h0 : p[1:0], 29'h0}, "pid");
        end
        $display("test pid done");
        ahb(usbc_pkg::OFS_INT_MASK, 1'b1, 32'h10);
        ahb(usbc_pkg::OFS_XFER_SIZE, 1'b1, xs(usbc_pkg::PID_DATA1, 10'h2, 19'd100));
        ahb(usbc_pkg::OFS_CHAN_CTL, 1'b1, 32'h3);
        #1 chk("txPid", {30'h0, usbc_pkg::PID_DATA1}, {30'h0, txPid});
        host_u.sendEvt({1'b1, 16'h0}, 0);
        #1 chk("txPid", {30'h0, usbc_pkg::PID_DATA0}, {30'h0, txPid});
        host_u.sendEvt({4'h0, 1'b1, 1'b0, 11'd64}, 2);
        rdChk(usbc_pkg::OFS_XFER_SIZE, '1, xs(usbc_pkg::PID_DATA0, 10'h1, 19'd36), "xfer");
        host_u.sendEvt({1'b1, 16'h0}, 0);
        #1 chkB("irq", 1'b1, irq);
        rdChk(usbc_pkg::OFS_XFER_SIZE, '1, xs(usbc_pkg::PID_DATA1, 10'h0, 19'd36), "xfer");
        rdChk(usbc_pkg::OFS_INT_STAT, 32'h10, 32'h10, "done");
        #1 chkB("irq", 1'b0, irq);
        $display("test out done");
        ahb(usbc_pkg::OFS_XFER_SIZE, 1'b1, xs(usbc_pkg::PID_DATA0, 10'h2, 19'd128));
        ahb(usbc_pkg::OFS_CHAN_CTL, 1'b1, 32'h1);
        host_u.sendEvt({2'h1, usbc_pkg::PID_DATA1, 13'h0}, 0);
        rdChk(usbc_pkg::OFS_INT_STAT, 32'h1, 32'h1, "togErr");
        rdChk(usbc_pkg::OFS_XFER_SIZE, '1, xs(usbc_pkg::PID_DATA0, 10'h2, 19'd128), "xfer");
        host_u.sendEvt({5'h0, 1'b1, 11'd64}, 0);
        rdChk(usbc_pkg::OFS_XFER_SIZE, '1, xs(usbc_pkg::PID_DATA0, 10'h2, 19'd64), "xfer");
        ahb(usbc_pkg::OFS_CHAN_CTL, 1'b1, 32'h0);
        $display("test in done");
        ahb(usbc_pkg::OFS_DEV_CFG, 1'b1, 32'h2a7);
        rdChk(usbc_pkg::OFS_DEV_CFG, '1, 32'h2a7, "devCfg");
        chkB("fullSpeedSel", 1'b1, fullSpeedSel);
        host_u.sendTok(7'h2a);
        #1 chkB("addrMatch", 1'b1, addrMatch);
        host_u.sendTok(7'h2b);
        #1 chkB("addrMatch", 1'b0, addrMatch);
        statusOutNonZero <= 1'b1;
        @(posedge sys_clk);
        #1 chkB("stall", 1'b1, statusOutStall);
        chkB("rxStoreEn", 1'b0, rxStoreEn);
        ahb(usbc_pkg::OFS_DEV_CFG, 1'b1, 32'h2a1);
        #1 chkB("fullSpeedSel", 1'b0, fullSpeedSel);
        chkB("stall", 1'b0, statusOutStall);
        statusOutNonZero <= 1'b0;
        $display("test config done");
        // Each end point code: flag clear shortly before, set shortly after
        for (int k = 0; k < 4; k++) begin
            ahb(usbc_pkg::OFS_DEV_CFG, 1'b1, {19'h0, k[1:0], 11'h0});
            host_u.sendSof();
            ahb(usbc_pkg::OFS_INT_STAT, 1'b0, 32'h0);
            repeat (FRM * (80 + 5 * k) / 100 - 8) @(posedge sys_clk);
            rdChk(usbc_pkg::OFS_INT_STAT, 32'h2, 32'h0, "frameEnd");
            repeat (10) @(posedge sys_clk);
            rdChk(usbc_pkg::OFS_INT_STAT, 32'h2, 32'h2, "frameEnd");
        end
        $display("test frame done");
        ahb(usbc_pkg::OFS_DEV_CTL, 1'b1, 32'h200);
        #1 chkB("outNak", 1'b1, outNak);
        chkB("rxStoreEn", 1'b0, rxStoreEn);
        ahb(usbc_pkg::OFS_DEV_CTL, 1'b1, 32'h80);
        #1 chkB("inNak", 1'b1, inNak);
        rdChk(usbc_pkg::OFS_INT_STAT, 32'hc, 32'h0, "nakEff");
        repeat (8) @(posedge sys_clk);
        rdChk(usbc_pkg::OFS_INT_STAT, 32'hc, 32'hc, "nakEff");
        rdChk(usbc_pkg::OFS_DEV_CTL, '1, 32'h0c, "devCtl");
        ahb(usbc_pkg::OFS_DEV_CTL, 1'b1, 32'h500);
        #1 chkB("outNak", 1'b0, outNak);
        chkB("inNak", 1'b0, inNak);
        $display("test nak done");
        ahb(usbc_pkg::OFS_DEV_CTL, 1'b1, 32'h2);
        #1 chkB("pullupEn", 1'b0, pullupEn);
        ahb(usbc_pkg::OFS_DEV_CTL, 1'b1, 32'h1);
        #1 chkB("pullupEn", 1'b1, pullupEn);
        chkB("resume", 1'b0, resumeSignal);
        suspended <= 1'b1;
        @(posedge sys_clk);
        #1 chkB("resume", 1'b1, resumeSignal);
        $display("test wake done");
        tallyAndFinish();
    end
endmodule : tb_usb_fs_transfer_and_device_config

// >>> verif/usbc_host_model.sv
`timescale 1ns/1ns
module usbc_host_model (
    // Clock
    input  wire logic           sys_clk,
    // Host side traffic into the block
    output usbc_pkg::usbc_evt_s pktEvt,
    output usbc_pkg::usbc_tok_s token,
    output logic                sofPulse
);
    // ************************************************
    // Host bus events
    // ************************************************
    // Quiet bus at time zero
    initial begin
        pktEvt   = '0;
        token    = '0;
        sofPulse = 1'b0;
    end

    // One-cycle strobe; idle fields inverted so stale values never match
    task automatic sendEvt(input usbc_pkg::usbc_evt_s e, input int gap);
        pktEvt <= e;
        @(posedge sys_clk);
        pktEvt <= {2'h0, ~e.rxPid, 2'h0, ~e.byteCount};
        repeat (gap) @(posedge sys_clk);
    endtask : sendEvt

    // Token with a device address, then the address scrambled
    task automatic sendTok(input logic [6:0] a);
        token <= {1'b1, a};
        @(posedge sys_clk);
        token <= {1'b0, ~a};
    endtask : sendTok

    // Start of frame marker
    task automatic sendSof();
        sofPulse <= 1'b1;
        @(posedge sys_clk);
        sofPulse <= 1'b0;
    endtask : sendSof
endmodule : usbc_host_model
